//--- rtl/pdc_collector.sv
// Plane data collector: twelve deframing inputs into swapped readout halves
`timescale 1ns/1ps
module pdc_collector #(
    parameter int IN_DEPTH = 4,
    parameter int SWAP_CYCLES = pdc_pkg::SWAP_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Link side
    pdc_if.collector link,
    // Status
    output logic active_bank_o,
    output logic [pdc_pkg::NUM_LINKS-1:0] overflow_o,
    output logic [pdc_pkg::NUM_LINKS-1:0] frame_err_o
);
    import pdc_pkg::*;

    localparam int FP_W = $clog2(IN_DEPTH);

    logic [NUM_LINKS-1:0] fifo_valid;
    logic [NUM_LINKS-1:0] grant;
    logic [WORD_BITS-1:0] fifo_data [NUM_LINKS];
    logic swap;
    logic bank_ready_q;
    logic [CNT_W-1:0] wcnt_q;
    logic wbank_q;

    ////////////////////////////////////////////////////////////////////////
    // Per-input receive and buffer, all inputs run concurrently
    genvar g;
    generate
        for (g = 0; g < NUM_LINKS; g++) begin : g_rx
            logic [2:0] sync_q;
            logic lvl_q;
            logic busy_q;
            logic [3:0] cyc_q;
            logic [3:0] bit_q;
            logic [SYM_BITS-1:0] sym_q;
            logic byte_ok;
            logic byte_bad;
            logic [WORD_BITS-1:0] word_q;
            logic [3:0] bcnt_q;
            logic push;
            logic [WORD_BITS-1:0] mem [IN_DEPTH];
            logic [FP_W-1:0] wp_q;
            logic [FP_W-1:0] rp_q;
            logic [FP_W:0] cnt_q;
            logic ferr_q;
            logic ovf_q;

            // Three-stage pin synchroniser, level moves when last two agree
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync_q <= {3{IDLE_LEVEL}};
                    lvl_q <= IDLE_LEVEL;
                end else begin
                    sync_q <= {sync_q[1:0], link.ser[g]};
                    if (sync_q[2] == sync_q[1]) begin
                        lvl_q <= sync_q[2];
                    end
                end
            end

            // Symbol sampler: start low, sample mid-bit every bit period
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    busy_q <= 1'b0;
                    cyc_q <= '0;
                    bit_q <= '0;
                    sym_q <= '0;
                end else if (!busy_q) begin
                    if (!lvl_q) begin
                        busy_q <= 1'b1;
                        // First sample falls on the start bit's second clock
                        cyc_q <= 4'(BIT_CYC / 2 - 1);
                        bit_q <= '0;
                    end
                end else if (cyc_q == '0) begin
                    sym_q <= {lvl_q, sym_q[SYM_BITS-1:1]};
                    cyc_q <= 4'(BIT_CYC - 1);
                    bit_q <= bit_q + 4'd1;
                    if (bit_q == 4'(SYM_BITS - 1)) begin
                        busy_q <= 1'b0;
                    end
                end else begin
                    cyc_q <= cyc_q - 4'd1;
                end
            end

            // A symbol ends on the stop bit; framing must be start 0, stop 1
            assign byte_ok = busy_q && cyc_q == '0 && bit_q == 4'(SYM_BITS - 1)
                             && lvl_q && !sym_q[1];
            assign byte_bad = busy_q && cyc_q == '0 && bit_q == 4'(SYM_BITS - 1)
                              && !(lvl_q && !sym_q[1]);

            // Gather twelve bytes, first byte in the low bits
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    word_q <= '0;
                    bcnt_q <= '0;
                    ferr_q <= 1'b0;
                end else if (byte_ok) begin
                    word_q <= {sym_q[SYM_BITS-1:2], word_q[WORD_BITS-1:BYTE_BITS]};
                    bcnt_q <= (bcnt_q == 4'(WORD_BYTES - 1)) ? 4'd0 : bcnt_q + 4'd1;
                end else if (byte_bad) begin
                    bcnt_q <= '0; // Drop the partial word to resynchronise
                    ferr_q <= 1'b1;
                end
            end
            assign push = byte_ok && bcnt_q == 4'(WORD_BYTES - 1);

            // Per-input word buffer absorbs bursts while the arbiter is busy
            always_ff @(posedge core_clk_i) begin
                if (push && cnt_q != (FP_W+1)'(IN_DEPTH)) begin
                    mem[wp_q] <= {sym_q[SYM_BITS-1:2], word_q[WORD_BITS-1:BYTE_BITS]};
                end
            end
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    wp_q <= '0;
                    rp_q <= '0;
                    cnt_q <= '0;
                    ovf_q <= 1'b0;
                end else begin
                    if (push && cnt_q != (FP_W+1)'(IN_DEPTH)) begin
                        wp_q <= (wp_q == FP_W'(IN_DEPTH - 1)) ? '0 : wp_q + 1'b1;
                    end else if (push) begin
                        ovf_q <= 1'b1;
                    end
                    if (grant[g]) begin
                        rp_q <= (rp_q == FP_W'(IN_DEPTH - 1)) ? '0 : rp_q + 1'b1;
                    end
                    cnt_q <= cnt_q + (FP_W+1)'(push && cnt_q != (FP_W+1)'(IN_DEPTH))
                             - (FP_W+1)'(grant[g]);
                end
            end
            assign fifo_valid[g] = cnt_q != '0;
            assign fifo_data[g] = mem[rp_q];
            // Sticky status flops, one bit of each status vector per input
            assign frame_err_o[g] = ferr_q;
            assign overflow_o[g] = ovf_q;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Round-robin pick of one input word per cycle
    logic [3:0] rr_q;
    logic [3:0] pick;
    logic pick_ok;
    logic wr_ok;
    assign wr_ok = wcnt_q < CNT_W'(BANK_WORDS) && !swap;
    always_comb begin
        logic [4:0] k;
        k = '0;
        pick = '0;
        pick_ok = 1'b0;
        grant = '0;
        for (int i = NUM_LINKS - 1; i >= 0; i--) begin
            k = 5'(rr_q) + 5'(i);
            if (k >= 5'(NUM_LINKS)) begin
                k = k - 5'(NUM_LINKS);
            end
            if (fifo_valid[k[3:0]]) begin
                pick = k[3:0];
                pick_ok = 1'b1;
            end
        end
        if (pick_ok && wr_ok) begin
            grant[pick] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readout store: two halves, slot = zero pad, word, address byte
    logic [SLOT_BITS-1:0] store [2*BANK_WORDS];
    logic [SLOT_BITS-1:0] rd_slot;
    logic [BEAT_BITS-1:0] rd_data_q;
    logic rd_valid_q;
    always_ff @(posedge core_clk_i) begin
        if (pick_ok && wr_ok) begin
            store[{wbank_q, wcnt_q[BANK_AW-1:0]}] <=
                {{(PAD_BYTES*BYTE_BITS){1'b0}}, fifo_data[pick],
                 {NIB_BITS'(0), pick}};
        end
    end
    assign rd_slot = store[{~wbank_q, link.rd_idx[IDX_W-1:1]}];

    // Write pointer and round-robin pointer
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wcnt_q <= '0;
            rr_q <= '0;
        end else if (swap) begin
            wcnt_q <= '0;
        end else if (pick_ok && wr_ok) begin
            wcnt_q <= wcnt_q + 1'b1;
            rr_q <= (pick == 4'(NUM_LINKS - 1)) ? 4'd0 : pick + 4'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Swap on period if the half holds a word, or near-full, only once the reader released the half
    logic [31:0] timer_q;
    logic [CNT_W-1:0] bank_count_q;
    assign swap = !bank_ready_q && (wcnt_q >= CNT_W'(BANK_WORDS - SWAP_MARGIN)
                  || (timer_q >= 32'(SWAP_CYCLES - 1) && wcnt_q != '0));
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_q <= '0;
            wbank_q <= 1'b0;
            bank_ready_q <= 1'b0;
            bank_count_q <= '0;
            active_bank_o <= 1'b0;
        end else begin
            timer_q <= (swap || timer_q >= 32'(SWAP_CYCLES - 1)) ? '0 : timer_q + 32'd1;
            if (swap) begin
                wbank_q <= ~wbank_q;
                active_bank_o <= ~wbank_q;
                bank_ready_q <= 1'b1;
                bank_count_q <= wcnt_q;
            end else if (link.rd_done) begin
                bank_ready_q <= 1'b0;
            end
        end
    end
    assign link.bank_ready = bank_ready_q;
    assign link.bank_count = bank_count_q;

    // One beat per request, answered the next cycle
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_q <= '0;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= link.rd_req && bank_ready_q;
            if (link.rd_req) begin
                rd_data_q <= link.rd_idx[0] ? rd_slot[SLOT_BITS-1:BEAT_BITS]
                                            : rd_slot[BEAT_BITS-1:0];
            end
        end
    end
    assign link.rd_data = rd_data_q;
    assign link.rd_valid = rd_valid_q;
endmodule : pdc_collector

//--- rtl/pdc_pkg.sv
// Shared constants and types for the plane data collector and its link partners
package pdc_pkg;
    // Link geometry
    localparam int NUM_LINKS = 12;
    localparam int SYM_BITS = 10;
    localparam int BYTE_BITS = 8;
    localparam int WORD_BYTES = 12;
    localparam int WORD_BITS = WORD_BYTES * BYTE_BITS;
    localparam int PAYLOAD_BITS = WORD_BITS - BYTE_BITS;
    localparam int NIB_BITS = 4;
    localparam int FRAME_BITS = WORD_BYTES * SYM_BITS;
    // Readout slot layout
    localparam int SLOT_BYTES = 16;
    localparam int PAD_BYTES = 3;
    localparam int SLOT_BITS = SLOT_BYTES * BYTE_BITS;
    localparam int BEAT_BITS = 64;
    localparam int BANK_WORDS = 256;
    localparam int BANK_AW = 8;
    localparam int IDX_W = BANK_AW + 1;
    localparam int CNT_W = BANK_AW + 1;
    localparam int SWAP_MARGIN = 16;
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int BIT_RATE_MBPS = 10;
    localparam int BIT_NS = 1000 / BIT_RATE_MBPS;
    localparam int BIT_CYC = BIT_NS / CLK_PERIOD_NS;
    localparam int SWAP_PERIOD_MS = 50;
    localparam int SWAP_CYC = SWAP_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    // Reset levels
    localparam logic IDLE_LEVEL = 1'b1;
    // Reader states, Gray along the path
    typedef enum logic [1:0] {
        PDC_RD_IDLE = 2'b00,
        PDC_RD_REQ = 2'b01,
        PDC_RD_WAIT = 2'b11,
        PDC_RD_DONE = 2'b10
    } pdc_rd_state_t;
endpackage : pdc_pkg

//--- rtl/pdc_if.sv
// Serial links and readout port between collector and its partners
`timescale 1ns/1ps
interface pdc_if;
    import pdc_pkg::*;
    logic [NUM_LINKS-1:0] ser;
    logic bank_ready;
    logic [CNT_W-1:0] bank_count;
    logic rd_req;
    logic [IDX_W-1:0] rd_idx;
    logic [BEAT_BITS-1:0] rd_data;
    logic rd_valid;
    logic rd_done;
    modport collector (
        input ser, rd_req, rd_idx, rd_done,
        output bank_ready, bank_count, rd_data, rd_valid
    );
    modport partner (
        output ser, rd_req, rd_idx, rd_done,
        input bank_ready, bank_count, rd_data, rd_valid
    );
endinterface : pdc_if

//--- rtl/pdc_partner.sv
// Upstream serial senders and readout processor end
`timescale 1ns/1ps
module pdc_partner (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Link side
    pdc_if.partner link,
    // Send requests, one per link
    input wire logic [pdc_pkg::NUM_LINKS-1:0] tx_valid_i,
    input wire logic [pdc_pkg::PAYLOAD_BITS-1:0] tx_payload_i [pdc_pkg::NUM_LINKS],
    input wire logic [pdc_pkg::NIB_BITS-1:0] tx_fe_id_i [pdc_pkg::NUM_LINKS],
    input wire logic [pdc_pkg::NIB_BITS-1:0] tx_src_in_i [pdc_pkg::NUM_LINKS],
    output logic [pdc_pkg::NUM_LINKS-1:0] tx_ready_o,
    // Readout words
    output logic [pdc_pkg::SLOT_BITS-1:0] word_o,
    output logic word_valid_o
);
    import pdc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Serial senders
    genvar g;
    generate
        for (g = 0; g < NUM_LINKS; g++) begin : g_tx
            logic [FRAME_BITS-1:0] sh_q;
            logic [6:0] left_q;
            logic [3:0] cyc_q;
            logic [FRAME_BITS-1:0] frame;
            logic [BYTE_BITS-1:0] addr_byte;
            logic line_q;
            logic rdy_q;
            // Each sender owns one bit of the shared line and ready vectors
            assign link.ser[g] = line_q;
            assign tx_ready_o[g] = rdy_q;
            // Upper nibble carries source input, lower the front-end id
            assign addr_byte = {tx_src_in_i[g], tx_fe_id_i[g]};
            // Each byte becomes start, eight data bits LSB first, stop
            always_comb begin
                frame = '0;
                for (int k = 0; k < WORD_BYTES; k++) begin
                    if (k == 0) begin
                        frame[k*SYM_BITS +: SYM_BITS] = {1'b1, addr_byte, 1'b0};
                    end else begin
                        frame[k*SYM_BITS +: SYM_BITS] =
                            {1'b1, tx_payload_i[g][(k-1)*BYTE_BITS +: BYTE_BITS], 1'b0};
                    end
                end
            end
            // Shift out one bit every bit period
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sh_q <= '0;
                    left_q <= '0;
                    cyc_q <= '0;
                    line_q <= IDLE_LEVEL;
                    rdy_q <= 1'b0;
                end else if (left_q == '0) begin
                    line_q <= IDLE_LEVEL;
                    rdy_q <= !(tx_valid_i[g] && rdy_q);
                    if (tx_valid_i[g] && rdy_q) begin
                        sh_q <= frame;
                        left_q <= 7'(FRAME_BITS);
                        cyc_q <= '0;
                    end
                end else if (cyc_q == '0) begin
                    line_q <= sh_q[0];
                    sh_q <= sh_q >> 1;
                    left_q <= left_q - 7'd1;
                    cyc_q <= 4'(BIT_CYC - 1);
                end else begin
                    cyc_q <= cyc_q - 4'd1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Readout processor
    pdc_rd_state_t state_q;
    logic rd_req_q;
    logic rd_done_q;
    logic [IDX_W-1:0] idx_q;
    logic [BEAT_BITS-1:0] lo_q;
    assign link.rd_req = rd_req_q;
    assign link.rd_done = rd_done_q;
    assign link.rd_idx = idx_q;

    // Fetch each slot as two beats, release the half when all are read
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= PDC_RD_IDLE;
            rd_req_q <= 1'b0;
            rd_done_q <= 1'b0;
            idx_q <= '0;
            lo_q <= '0;
            word_o <= '0;
            word_valid_o <= 1'b0;
        end else begin
            word_valid_o <= 1'b0;
            rd_req_q <= 1'b0;
            rd_done_q <= 1'b0;
            case (state_q)
                PDC_RD_IDLE: begin
                    idx_q <= '0;
                    if (link.bank_ready && link.bank_count != '0) begin
                        state_q <= PDC_RD_REQ;
                        rd_req_q <= 1'b1;
                    end else if (link.bank_ready) begin
                        state_q <= PDC_RD_DONE;
                        rd_done_q <= 1'b1;
                    end
                end
                PDC_RD_REQ: state_q <= PDC_RD_WAIT;
                PDC_RD_WAIT: begin
                    if (link.rd_valid) begin
                        if (idx_q[0]) begin
                            word_o <= {link.rd_data, lo_q};
                            word_valid_o <= 1'b1;
                        end else begin
                            lo_q <= link.rd_data;
                        end
                        // Last beat is the high beat of the last handed slot
                        if (idx_q == IDX_W'({link.bank_count - CNT_W'(1), 1'b1})) begin
                            state_q <= PDC_RD_DONE;
                            rd_done_q <= 1'b1;
                        end else begin
                            idx_q <= idx_q + 1'b1;
                            state_q <= PDC_RD_REQ;
                            rd_req_q <= 1'b1;
                        end
                    end
                end
                PDC_RD_DONE: state_q <= PDC_RD_IDLE;
                default: state_q <= PDC_RD_IDLE;
            endcase
        end
    end
endmodule : pdc_partner

//--- dv/pdc_monitor.sv
// Checker for the readout handshake and serial lines between the two ends
`timescale 1ns/1ps
module pdc_monitor (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Watched link signals
    input wire logic [pdc_pkg::NUM_LINKS-1:0] ser,
    input wire logic bank_ready,
    input wire logic [pdc_pkg::CNT_W-1:0] bank_count,
    input wire logic rd_req,
    input wire logic [pdc_pkg::IDX_W-1:0] rd_idx,
    input wire logic [pdc_pkg::BEAT_BITS-1:0] rd_data,
    input wire logic rd_valid,
    input wire logic rd_done
);
    import pdc_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////
    // Beat answers follow their request by exactly one cycle
    AST_BEAT_ANSWER: assert property (rd_req && bank_ready |=> rd_valid)
        else $error("beat request not answered next cycle");
    AST_BEAT_CAUSE: assert property (rd_valid |-> $past(rd_req) && $past(bank_ready))
        else $error("beat answer without request");
    AST_DATA_HOLD: assert property ($changed(rd_data) |-> rd_valid)
        else $error("beat data moved outside an answer");
    AST_REQ_SPACING: assert property (rd_req |=> !rd_req)
        else $error("beat requests back to back");
    AST_IDX_RANGE: assert property (rd_req |-> rd_idx < {bank_count, 1'h0})
        else $error("beat index beyond handed half");
    ////////////////////////////////////////
    // Handed half is bounded, held and released only by the reader
    AST_COUNT_LIMIT: assert property (bank_ready |-> bank_count <= CNT_W'(BANK_WORDS))
        else $error("handed half holds more slots than a half");
    AST_COUNT_HOLD: assert property ($past(bank_ready) && bank_ready |-> $stable(bank_count))
        else $error("slot count moved while handed");
    AST_HALF_HELD: assert property (bank_ready && !rd_done |=> bank_ready)
        else $error("handed half withdrawn before release");
    AST_RELEASE: assert property (rd_done |=> !bank_ready)
        else $error("handed half not taken back after release");
    AST_DONE_OWNED: assert property (rd_done |-> bank_ready)
        else $error("release without a handed half");
    ////////////////////////////////////////
    // Every serial bit lasts two clocks
    for (genvar g = 0; g < NUM_LINKS; g++) begin : g_line
        AST_BIT_WIDTH: assert property ($changed(ser[g]) |=> $stable(ser[g]))
            else $error("serial bit shorter than two clocks");
    end
endmodule : pdc_monitor

//--- dv/testbench.sv
// Self-checking bench for the collector facing its link partner
`timescale 1ns/1ps
module testbench;
    import pdc_pkg::*;
    typedef struct {
        logic [3:0] link;
        logic [PAYLOAD_BITS-1:0] payload;
        logic [3:0] fe;
        logic [3:0] src;
        logic [7:0] addr;
    } pdc_row_t;
    localparam logic [9:0] BAD_SYM = 10'h0AA;
    logic core_clk_i;
    logic rst_n_i;
    logic [NUM_LINKS-1:0] tx_valid;
    logic [PAYLOAD_BITS-1:0] tx_payload [NUM_LINKS];
    logic [3:0] tx_fe [NUM_LINKS];
    logic [3:0] tx_src [NUM_LINKS];
    logic [NUM_LINKS-1:0] tx_ready;
    logic [SLOT_BITS-1:0] word;
    logic word_valid;
    logic active_bank;
    logic [NUM_LINKS-1:0] overflow;
    logic [NUM_LINKS-1:0] frame_err;
    logic [NUM_LINKS-1:0] err_overflow;
    logic [NUM_LINKS-1:0] err_frame;
    logic [NUM_LINKS-1:0] seen;
    logic exp_bank;
    int bad_count;
    int check_count;
    pdc_row_t rows [4];
    pdc_if link ();
    pdc_if bad_if ();
    ////////////////////////////////////////
    // Both ends joined, plus a lone collector fed by the bench
    pdc_partner pdc_partner_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .link(link.partner), .tx_valid_i(tx_valid), .tx_payload_i(tx_payload),
        .tx_fe_id_i(tx_fe), .tx_src_in_i(tx_src), .tx_ready_o(tx_ready),
        .word_o(word), .word_valid_o(word_valid));
    pdc_collector #(.SWAP_CYCLES(200)) pdc_collector_inst (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .link(link.collector), .active_bank_o(active_bank),
        .overflow_o(overflow), .frame_err_o(frame_err));
    pdc_collector #(.SWAP_CYCLES(200)) pdc_collector_err_inst (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .link(bad_if.collector), .active_bank_o(),
        .overflow_o(err_overflow), .frame_err_o(err_frame));
    pdc_monitor pdc_monitor_inst (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .ser(link.ser), .bank_ready(link.bank_ready), .bank_count(link.bank_count),
        .rd_req(link.rd_req), .rd_idx(link.rd_idx), .rd_data(link.rd_data),
        .rd_valid(link.rd_valid), .rd_done(link.rd_done));
    ////////////////////////////////////////
    // Clock
    initial begin
        core_clk_i = 1'h0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up
    // Comparisons
    task automatic cmp_word(input string name, input logic [SLOT_BITS-1:0] exp,
        input logic [SLOT_BITS-1:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_word
    task automatic cmp_flags(input string name, input logic [11:0] exp, input logic [11:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp_flags
    // One clock, then the fixed drive delay
    task automatic tick();
        @(posedge core_clk_i);
        #2;
    endtask : tick
    // Bounded wait for a readout word
    task automatic wait_word();
        int n;
        n = 0;
        do begin
            tick();
            n++;
        end while (word_valid !== 1'h1 && n < 3000);
        if (word_valid !== 1'h1) begin
            bad_count++;
            $display("CHECK FAILED word_valid expected 1 seen timeout");
            wrap_up();
        end
    endtask : wait_word
    // Launch one word and optionally watch its first symbol on the wire
    task automatic send(input pdc_row_t r, input bit chk);
        logic [9:0] sym;
        sym = {1'h1, r.src, r.fe, 1'h0};
        tx_payload[r.link] = r.payload;
        tx_fe[r.link] = r.fe;
        tx_src[r.link] = r.src;
        tx_valid[r.link] = 1'h1;
        tick();
        tx_valid[r.link] = 1'h0;
        for (int i = 0; i < SYM_BITS; i++) begin
            tick();
            if (chk) cmp_flags("ser bit", {11'h0, sym[i]}, {11'h0, link.ser[r.link]});
            tick();
        end
    endtask : send
    ////////////////////////////////////////
    // Main sequence
    initial begin
        tx_valid = '0;
        rst_n_i = 1'h0;
        bad_if.ser = '1;
        bad_if.rd_req = 1'h0;
        bad_if.rd_idx = '0;
        bad_if.rd_done = 1'h0;
        bad_count = 0;
        check_count = 0;
        exp_bank = 1'h0;
        for (int g = 0; g < NUM_LINKS; g++) begin
            tx_payload[g] = '0;
            tx_fe[g] = '0;
            tx_src[g] = '0;
        end
        rows[0] = '{4'h0, {88{1'h1}}, 4'h0, 4'hF, 8'h00};
        rows[1] = '{4'hB, 88'h0, 4'hF, 4'h0, 8'h0B};
        rows[2] = '{4'h5, 88'h0123456789ABCDEF012345, 4'hA, 4'h5, 8'h05};
        rows[3] = '{4'h7, 88'hFEDCBA9876543210FEDCBA, 4'h3, 4'hC, 8'h07};
        repeat (4) @(posedge core_clk_i);
        #2;
        rst_n_i = 1'h1;
        repeat (2) tick();
        // Ordinary words, one per half
        foreach (rows[k]) begin
            send(rows[k], 1'h1);
            wait_word();
            exp_bank = ~exp_bank;
            cmp_word("slot", {24'h0, rows[k].payload, rows[k].src, rows[k].fe, rows[k].addr}, word);
            cmp_flags("active_bank", {11'h0, exp_bank}, {11'h0, active_bank});
            repeat (20) tick();
        end
        // All inputs at once
        for (int g = 0; g < NUM_LINKS; g++) begin
            tx_payload[g] = {11{4'hA, 4'(g)}};
            tx_fe[g] = 4'(g);
            tx_src[g] = 4'(11 - g);
        end
        tx_valid = '1;
        tick();
        tx_valid = '0;
        seen = '0;
        repeat (NUM_LINKS) begin
            wait_word();
            seen[word[3:0]] = 1'h1;
            cmp_word("slot", {24'h0, {11{4'hA, word[3:0]}}, 4'(11 - word[3:0]), word[3:0], 4'h0, word[3:0]}, word);
        end
        cmp_flags("inputs seen", 12'hFFF, seen);
        cmp_flags("overflow", 12'h000, overflow);
        cmp_flags("frame_err", 12'h000, frame_err);
        repeat (20) tick();
        cmp_flags("ser idle", 12'hFFF, link.ser);
        // Reset in mid-frame
        tx_valid[3] = 1'h1;
        tick();
        tx_valid[3] = 1'h0;
        repeat (60) tick();
        rst_n_i = 1'h0;
        repeat (2) tick();
        cmp_flags("tx_ready", 12'h000, tx_ready);
        cmp_flags("ser reset", 12'hFFF, link.ser);
        cmp_flags("status", 12'h000, overflow | frame_err | {11'h0, active_bank});
        rst_n_i = 1'h1;
        tick();
        cmp_flags("tx_ready", 12'hFFF, tx_ready);
        tick();
        send(rows[2], 1'h0);
        wait_word();
        cmp_word("slot", {24'h0, rows[2].payload, rows[2].src, rows[2].fe, rows[2].addr}, word);
        // Broken stop bit on the lone collector
        for (int i = 0; i < SYM_BITS; i++) begin
            bad_if.ser[0] = BAD_SYM[i];
            repeat (2) tick();
        end
        bad_if.ser[0] = 1'h1;
        repeat (10) tick();
        cmp_flags("frame_err", 12'h001, err_frame);
        cmp_flags("overflow", 12'h000, err_overflow);
        wrap_up();
    end
endmodule : testbench
